// File: common/guard_pkg.sv
// shared constants for the flash reset and write guard block
package guard_pkg;
  // sector count and sector index width
  localparam int NUM_SECTORS = 11;
  localparam int SECT_W = 4;
  localparam int ADDR_W = 19;
  // sector boundaries (array byte addresses, lowest address of each sector)
  localparam logic [18:0] BASE_S10 = 19'h78000;
  localparam logic [18:0] BASE_S9 = 19'h76000;
  localparam logic [18:0] BASE_S8 = 19'h74000;
  localparam logic [18:0] BASE_S7 = 19'h70000;
  // highest sector overall, and highest sector of the lower 64-Kbyte block run
  localparam logic [3:0] TOP_SECTOR = 4'ha;
  localparam logic [3:0] LOW_TOP_SECTOR = 4'h6;
  // command codes that start array changes
  localparam logic [7:0] CMD_PROGRAM_A = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_B = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h21;
  localparam logic [7:0] CMD_UNIFORM_ERASE = 8'h20;
  // lock register layout and reset value
  localparam logic [7:0] LOCK_RESET = 8'h01;
  localparam int LOCK_WRITE_BIT = 0;
  localparam int LOCK_DOWN_BIT = 1;
  localparam int LOCK_READ_BIT = 2;
  localparam logic [7:0] LOCK_USED_MASK = 8'h07;
  // register offsets: lock registers at index 0..10, then status
  localparam logic [3:0] REG_STATUS = 4'hb;
  localparam logic [3:0] REG_MODE = 4'hc;
  // status bits
  localparam int STAT_READY_BIT = 7;
  localparam int STAT_LOCK_ERR_BIT = 1;
  localparam int STAT_ABORT_BIT = 0;
  // timing in ns at 250 MHz
  localparam int CLK_PERIOD_NS = 4;
  localparam int BUS_RECOVERY_NS = 1000;
  localparam int MUXED_RECOVERY_NS = 1000;
  localparam int RESET_PULSE_MIN_NS = 100;
  localparam int BUS_RECOVERY_CYC =
    (BUS_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MUXED_RECOVERY_CYC =
    (MUXED_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYC =
    (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_W = 10;
  // reset latency added when an operation is aborted
  localparam int ABORT_LATENCY_CYC = 16;
endpackage

// File: rtl/sector_map.sv
// address to sector decoder for the boot-sector layout
`timescale 1ns/1ns
module sector_map
  import guard_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr,
  output logic [SECT_W-1:0] sector
);
  // top 64-Kbyte block splits into 32K, 8K, 8K, 16K; the rest are 64K
  always_comb begin
    if (addr >= BASE_S10) begin
      sector = 4'ha;
    end else if (addr >= BASE_S9) begin
      sector = 4'h9;
    end else if (addr >= BASE_S8) begin
      sector = 4'h8;
    end else if (addr >= BASE_S7) begin
      sector = 4'h7;
    end else begin
      sector = {1'b0, addr[18:16]}; // 64K blocks 0..6
    end
  end
endmodule // sector_map

// File: rtl/recovery_timer.sv
// reset recovery down-counter gating the command interface
`timescale 1ns/1ns
module recovery_timer
  import guard_pkg::*;
#(
  parameter int COUNT_W = RECOVERY_W
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [COUNT_W-1:0] load,
  output logic busy
);
  logic [COUNT_W-1:0] count; // cycles still to wait

  initial begin
    if (COUNT_W < 2) $error("recovery_timer: COUNT_W too small");
  end

  // load on start, count to zero; busy while nonzero
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else if (start) begin
      count <= load;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign busy = (count != '0);
endmodule // recovery_timer

// File: rtl/flash_reset_and_write_guard.sv
// reset handling, guard pins and sector lock registers of the boot flash
`timescale 1ns/1ns
module flash_reset_and_write_guard
  import guard_pkg::*;
#(
  parameter int BUS_RECOVERY = BUS_RECOVERY_CYC,
  parameter int MUXED_RECOVERY = MUXED_RECOVERY_CYC,
  parameter int ABORT_LATENCY = ABORT_LATENCY_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic init_n,
  input wire logic top_boot_guard_n,
  input wire logic array_guard_n,
  input wire logic hub_mode,
  input wire logic muxed_mode,
  input wire logic op_start,
  input wire logic [7:0] op_cmd,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire logic op_done,
  input wire logic read_req,
  input wire logic [ADDR_W-1:0] read_addr,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic op_go,
  output logic op_refused,
  output logic op_abort,
  output logic read_blank,
  output logic array_select,
  output logic drive_enable,
  output logic circuits_on,
  output logic read_array_mode,
  output logic command_ready
);
  // operation life cycle: idle until an accepted request, busy until
  // the sequencer reports done, then idle again. a reset pin dropped
  // while busy kills the operation and parks the tracker in a latency
  // state before it settles in reset (or in idle if the pins are back high); the array contents at the
  // aborted address are then not to be trusted. a request that meets
  // a guard pin or a write-lock bit never leaves idle, it only raises
  // the refusal strobe and the sticky lock error.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, // waiting for an operation
    ST_BUSY = 4'b0010, // sequencer altering the array
    ST_LATENCY = 4'b0100, // extra latency after abort
    ST_RESET = 4'b1000 // held in device reset
  } op_state_t;

  op_state_t state; // operation tracker
  logic dev_reset; // either reset pin low
  logic dev_reset_q; // previous value, for release edge
  logic [7:0] lock [NUM_SECTORS]; // sector lock registers
  logic lock_err; // sticky sector-lock error
  logic abort_seen; // sticky abort flag
  logic [SECT_W-1:0] op_sector; // target of the requested op
  logic [SECT_W-1:0] rd_sector; // target of a read
  logic recovering; // command interface still blocked
  logic [RECOVERY_W-1:0] recovery_load; // recovery count for mode
  logic [7:0] latency_cnt; // abort latency counter
  logic protected_op; // combined protection verdict
  logic guard_hit; // a guard pin covers the target
  logic is_program; // byte program command
  logic is_sector_erase; // standard sector erase
  logic is_uniform_erase; // uniform 64K erase
  logic accept; // operation request is taken for a go or a refusal
  logic release_edge; // reset pins just returned high

  initial begin
    if (BUS_RECOVERY < 1 || BUS_RECOVERY >= (1 << RECOVERY_W))
      $error("BUS_RECOVERY out of range");
    if (MUXED_RECOVERY < 1 || MUXED_RECOVERY >= (1 << RECOVERY_W))
      $error("MUXED_RECOVERY out of range");
    if (ABORT_LATENCY < 1 || ABORT_LATENCY > 255)
      $error("ABORT_LATENCY out of range");
  end

  // status register read, which also clears the sticky flags
  function automatic logic hits_status(input logic rd,
                                       input logic [3:0] addr);
    return rd && (addr == REG_STATUS);
  endfunction

  // decode both address paths through the same fixed map
  sector_map u_op_map (
    .addr(op_addr),
    .sector(op_sector)
  );
  sector_map u_rd_map (
    .addr(read_addr),
    .sector(rd_sector)
  );

  assign dev_reset = !reset_n || !init_n;
  // the release edge loads the recovery timer, which is busy only from
  // the next cycle on, so the command gate also holds that one cycle
  assign release_edge = dev_reset_q && !dev_reset;
  // each interface has its own recovery interval
  assign recovery_load = muxed_mode ? RECOVERY_W'(MUXED_RECOVERY)
                                    : RECOVERY_W'(BUS_RECOVERY);

  // counts down the recovery after a reset pin release
  recovery_timer #(
    .COUNT_W(RECOVERY_W)
  ) u_recovery (
    .clk(clk),
    .rst(rst),
    .start(release_edge),
    .load(recovery_load),
    .busy(recovering)
  );

  // previous reset level, to find the release edge
  always_ff @(posedge clk) begin
    if (rst) begin
      dev_reset_q <= 1'b1;
    end else begin
      dev_reset_q <= dev_reset;
    end
  end

  // command classes
  assign is_program = (op_cmd == CMD_PROGRAM_A) || (op_cmd == CMD_PROGRAM_B);
  assign is_sector_erase = (op_cmd == CMD_SECTOR_ERASE);
  assign is_uniform_erase = (op_cmd == CMD_UNIFORM_ERASE);

  // guard pin coverage of the target, mode and command dependent
  // sector 10 always follows the top-boot pin. sectors 9..7 follow it
  // in hub mode and for the uniform erase, which wipes the whole top
  // 64K run at once; otherwise they follow the array pin like 6..0.
  always_comb begin
    guard_hit = 1'b0;
    if (op_sector == TOP_SECTOR) begin
      guard_hit = !top_boot_guard_n;
    end else if (op_sector > LOW_TOP_SECTOR) begin
      if (hub_mode) begin
        guard_hit = !top_boot_guard_n;
      end else if (is_uniform_erase) begin
        guard_hit = !top_boot_guard_n;
      end else begin
        guard_hit = !array_guard_n;
      end
    end else begin
      // 6..0: array guard in every mode and command
      guard_hit = !array_guard_n;
    end
  end

  // pins win over registers; write-lock counted only when pins allow
  assign protected_op = guard_hit || lock[op_sector][LOCK_WRITE_BIT];

  // requests are ignored in reset, in recovery and while busy;
  // the registered gate is used so that its rise and the first
  // accepted command line up, and the release edge itself, where the
  // timer has not loaded yet, stays shut
  assign accept = op_start && (state == ST_IDLE) && command_ready
                  && (is_program || is_sector_erase || is_uniform_erase);

  // operation tracker; guard pins sampled only at the start
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_RESET;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (dev_reset) begin
            state <= ST_RESET;
          end else if (accept && !protected_op) begin
            state <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (dev_reset) begin
            state <= ST_LATENCY;
          end else if (op_done) begin
            state <= ST_IDLE;
          end
        end
        ST_LATENCY: begin
          // latency runs to end even if reset still held
          if (latency_cnt == 8'h00) begin
            state <= dev_reset ? ST_RESET : ST_IDLE;
          end
        end
        ST_RESET: begin
          if (!dev_reset) begin
            state <= ST_IDLE; // back in read-array mode
          end
        end
      endcase
    end
  end

  // abort latency counter
  always_ff @(posedge clk) begin
    if (rst) begin
      latency_cnt <= 8'h00;
    end else if (state == ST_BUSY && dev_reset) begin
      latency_cnt <= 8'(ABORT_LATENCY - 1);
    end else if (latency_cnt != 8'h00) begin
      latency_cnt <= latency_cnt - 8'h01;
    end
  end

  // one-cycle strobes toward the sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      op_go <= 1'b0;
      op_refused <= 1'b0;
      op_abort <= 1'b0;
    end else begin
      op_go <= !dev_reset && accept && !protected_op;
      op_refused <= !dev_reset && accept && protected_op;
      op_abort <= (state == ST_BUSY) && dev_reset;
    end
  end

  // sticky lock error; a new event wins over a status read clear
  always_ff @(posedge clk) begin
    if (rst || dev_reset) begin
      lock_err <= 1'b0;
    end else if (accept && protected_op) begin
      lock_err <= 1'b1;
    end else if (hits_status(reg_rd, reg_addr)) begin
      lock_err <= 1'b0;
    end
  end

  // sticky abort flag; it must outlive the pin reset that caused it,
  // since an abort only ever happens with a reset pin held low
  always_ff @(posedge clk) begin
    if (rst) begin
      abort_seen <= 1'b0;
    end else if (state == ST_LATENCY) begin
      abort_seen <= 1'b1;
    end else if (hits_status(reg_rd, reg_addr)) begin
      abort_seen <= 1'b0;
    end
  end

  // lock registers; guard pins never touch them
  generate
    for (genvar s = 0; s < NUM_SECTORS; s++) begin : g_lock
      always_ff @(posedge clk) begin
        if (rst || dev_reset) begin
          lock[s] <= LOCK_RESET;
        end else if (reg_wr && command_ready && reg_addr == 4'(s)
                     && !lock[s][LOCK_DOWN_BIT]) begin
          // lock-down freezes the register until reset
          lock[s] <= reg_wdata & LOCK_USED_MASK;
        end
      end
    end
  endgenerate

  // register read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr < 4'(NUM_SECTORS)) begin
        reg_rdata <= lock[reg_addr]; // pins not visible
      end else if (reg_addr == REG_STATUS) begin
        reg_rdata <= {(state == ST_IDLE), 5'b0, lock_err, abort_seen};
      end else if (reg_addr == REG_MODE) begin
        reg_rdata <= {6'b0, recovering, read_array_mode};
      end else begin
        reg_rdata <= 8'h00; // unmapped
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // read-lock blanks array reads, even under an active guard
  always_ff @(posedge clk) begin
    if (rst) begin
      read_blank <= 1'b0;
    end else begin
      read_blank <= read_req && lock[rd_sector][LOCK_READ_BIT];
    end
  end

  // pin-level effects of reset
  always_ff @(posedge clk) begin
    if (rst) begin
      array_select <= 1'b0;
      drive_enable <= 1'b0;
      circuits_on <= 1'b0;
      read_array_mode <= 1'b1;
      command_ready <= 1'b0;
    end else begin
      array_select <= !dev_reset;
      drive_enable <= !dev_reset;
      circuits_on <= !dev_reset;
      if (dev_reset) begin
        read_array_mode <= 1'b1;
      end else if (accept && !protected_op) begin
        // leave read-array mode on the edge that launches op_go
        read_array_mode <= 1'b0;
      end else if (state == ST_IDLE) begin
        read_array_mode <= 1'b1;
      end
      command_ready <= !dev_reset && !recovering && !release_edge;
    end
  end
endmodule // flash_reset_and_write_guard

// File: verif/op_sequencer_model.sv
// array sequencer model answering accepted operations with op_done
`timescale 1ns/1ns
module op_sequencer_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic init_n,
  input wire logic op_go,
  input wire logic [3:0] dly,
  output logic op_done
);
  logic [3:0] cnt; // cycles left in the running operation
  // a reset pin kills the operation, so no stray done after an abort
  always_ff @(posedge clk) begin
    if (rst || !reset_n || !init_n) begin
      cnt <= 4'h0;
      op_done <= 1'b0;
    end else begin
      op_done <= (cnt == 4'h1);
      if (op_go) cnt <= dly; // short dly is prompt, long is slow
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
  end
endmodule // op_sequencer_model

// File: verif/flash_reset_and_write_guard_asserts.sv
// checker for reset and operation handshakes of the write guard
`timescale 1ns/1ns
module guard_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic init_n,
  input wire logic op_start,
  input wire logic op_go,
  input wire logic op_refused,
  input wire logic op_abort,
  input wire logic array_select,
  input wire logic drive_enable,
  input wire logic circuits_on,
  input wire logic read_array_mode,
  input wire logic command_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // array, drivers and circuits all off while a pin is low
  property p_off; (!reset_n || !init_n) |=>
    !array_select && !drive_enable && !circuits_on; endproperty
  a_off: assert property (p_off) else $error("outputs on in reset");
  property p_rdy_low; (!reset_n || !init_n) |=> !command_ready; endproperty
  a_rdy_low: assert property (p_rdy_low) else $error("ready in reset");
  // recovery keeps commands shut for a few cycles after release
  property p_recov; $rose(reset_n) && init_n |-> !command_ready [*3];
  endproperty
  a_recov: assert property (p_recov) else $error("no recovery");
  property p_ram; $rose(reset_n) |-> ##[0:2] read_array_mode; endproperty
  a_ram: assert property (p_ram) else $error("not read array");
  property p_busy; op_go |-> !read_array_mode && $past(command_ready);
  endproperty
  a_busy: assert property (p_busy) else $error("bad op start");
  property p_one; !(op_go && op_refused); endproperty
  a_one: assert property (p_one) else $error("go and refuse");
  property p_cause; (op_go || op_refused) |-> $past(op_start); endproperty
  a_cause: assert property (p_cause) else $error("answer uncaused");
  property p_abort; op_abort |-> ($past(reset_n) == 1'b0 ||
    $past(init_n) == 1'b0); endproperty
  a_abort: assert property (p_abort) else $error("abort uncaused");
endmodule // guard_asserts
bind flash_reset_and_write_guard guard_asserts i_guard_asserts (.*);

// File: verif/flash_reset_and_write_guard_bench.sv
// testbench for the flash reset and write guard
`timescale 1ns/1ns
module flash_reset_and_write_guard_bench import guard_pkg::*;;
  logic clk = 0, rst = 1, reset_n = 1, init_n = 1;
  logic top_boot_guard_n = 1, array_guard_n = 1, hub_mode = 0;
  logic muxed_mode = 0, op_start = 0, read_req = 0;
  logic reg_wr = 0, reg_rd = 0, op_done;
  logic [7:0] op_cmd = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [18:0] op_addr = 19'h00000, read_addr = 19'h00000;
  logic [3:0] reg_addr = 4'h0, dly = 4'h1;
  logic op_go, op_refused, op_abort, read_blank, array_select;
  logic drive_enable, circuits_on, read_array_mode, command_ready;
  int failures = 0, n_tests = 0, ab = 0;
  logic [4:0] m; // mode, pins and command of one sweep step
  logic [7:0] cmds [4] = '{8'h40, 8'h10, 8'h21, 8'h20};
  flash_reset_and_write_guard #(.BUS_RECOVERY(4), .MUXED_RECOVERY(4),
    .ABORT_LATENCY(2)) i_flash_reset_and_write_guard (.*);
  op_sequencer_model i_op_sequencer_model (.*);
  initial forever #2 clk = ~clk;
  // counts abort pulses, so a double pulse shows
  always @(posedge clk) if (op_abort === 1'b1) ab++;
  task wrap_up;
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(string n, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  // data stands only in the cycle after the strobe
  task rd(logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  task rb(logic [18:0] a, logic e);
    @(posedge clk);
    read_req <= 1; read_addr <= a;
    @(posedge clk);
    read_req <= 0;
    #1 chk("read_blank", {7'h0, e}, {7'h0, read_blank});
  endtask
  task ready;
    int i;
    for (i = 0; i < 40 && command_ready !== 1'b1; i++) @(posedge clk) #1;
    if (i == 40) begin failures++; wrap_up; end
  endtask
  // one operation; g is the expected accept, w waits for completion
  task op(logic [7:0] c, logic [18:0] a, logic g, logic w);
    int i;
    @(posedge clk);
    op_start <= 1; op_cmd <= c; op_addr <= a;
    @(posedge clk);
    op_start <= 0;
    #1 chk("go_refused", {6'h0, g, !g}, {6'h0, op_go, op_refused});
    if (g && w) begin
      for (i = 0; i < 30 && op_done !== 1'b1; i++) @(posedge clk) #1;
      if (i == 30) begin failures++; wrap_up; end
      repeat (3) @(posedge clk);
    end
  endtask
  // which pin guards a sector for a given mode and command
  function automatic logic prot(logic h, t, w, logic [7:0] c, int s);
    if (s >= 7 && (h || c == CMD_UNIFORM_ERASE || s == 10)) return !t;
    return !w;
  endfunction
  function automatic logic [18:0] sa(int s);
    case (s)
      7: return BASE_S7;
      8: return BASE_S8;
      9: return BASE_S9;
      10: return BASE_S10;
      default: return 19'(s) << 16;
    endcase
  endfunction
  // pin reset: check outputs off, hold beyond the minimum pulse
  task pin_reset(logic which);
    @(posedge clk);
    if (which) reset_n <= 0; else init_n <= 0;
    repeat (2) @(posedge clk);
    #1 chk("off", 8'h00, {array_select, drive_enable, circuits_on});
    repeat (30) @(posedge clk);
    reset_n <= 1; init_n <= 1;
    wr(4'h0, 8'h00); // ignored while recovering
    ready;
    rd(4'h0, LOCK_RESET);
    chk("mode", 8'h01, {7'h0, read_array_mode});
    rd(REG_MODE, 8'h01);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    ready;
    chk("on", 8'h07, {array_select, drive_enable, circuits_on});
    for (int i = 0; i < 11; i++) rd(4'(i), LOCK_RESET);
    op(CMD_PROGRAM_A, sa(0), 0, 1);
    rd(REG_STATUS, 8'h82);
    for (int i = 0; i < 11; i++) wr(4'(i), 8'h00);
    // every mode, pin pair, command and sector; pins set before each op
    for (int k = 0; k < 352; k++) begin
      @(posedge clk);
      m = 5'(k / 11);
      hub_mode <= m[4]; top_boot_guard_n <= m[3]; array_guard_n <= m[2];
      dly <= k[0] ? 4'h1 : 4'h6;
      op(cmds[m[1:0]], sa(k % 11), !prot(m[4], m[3], m[2], cmds[m[1:0]],
        k % 11), 1);
    end
    for (int i = 0; i < 11; i++) rd(4'(i), 8'h00);
    wr(4'h3, 8'h02);
    wr(4'h3, 8'h01);
    rd(4'h3, 8'h02);
    wr(4'h2, 8'h04);
    rb(sa(2), 1);
    rb(sa(1), 0);
    @(posedge clk);
    top_boot_guard_n <= 1; array_guard_n <= 1; dly <= 4'hf;
    op(CMD_PROGRAM_B, sa(5), 1, 0);
    pin_reset(1);
    chk("abort", 8'h01, 8'(ab));
    rd(REG_STATUS, 8'h81);
    rd(4'h3, LOCK_RESET);
    @(posedge clk);
    muxed_mode <= 1;
    pin_reset(0);
    wrap_up;
  end
endmodule // flash_reset_and_write_guard_bench
